// ---- core/brot_cfg.svh ----
// byte rotate unit constants
`ifndef BROT_CFG_SVH
`define BROT_CFG_SVH
`define BROT_W 8
`define BROT_OP_W 3
`define BROT_OP_NONE 3'h0
`define BROT_OP_RL_ACC 3'h1
`define BROT_OP_RLC_MEM 3'h2
`define BROT_OP_RLC_ACC 3'h3
`define BROT_OP_RR_MEM 3'h4
`define BROT_RST_BYTE 8'h00
`endif

// ---- core/brot_pkg.sv ----
// byte rotate unit types
package brot_pkg;
  // decoded operation control
  typedef struct packed {
    logic go;
    logic left;
    logic thru_c;
    logic to_acc;
  } brot_ctl_t;
  // result carrier
  typedef struct packed {
    logic mem_we;
    logic acc_we;
    logic c_we;
    logic c;
    logic [7:0] data;
  } brot_res_t;
endpackage

// ---- core/brot_unit.sv ----
// byte rotate datapath
`timescale 1ns/1ps
`default_nettype none
`include "brot_cfg.svh"

// Overview of operation
// RULE1 - left rotate to accumulator, bit7 wraps, no flags
// RULE2 - accumulator variant leaves memory untouched
// RULE3 - nine-bit left ring through carry to memory
// RULE4 - carry ring result to accumulator, memory kept
// RULE5 - right rotate, bit0 wraps to bit7, memory
// RULE6 - eight-bit operands; opcode picks direction, carry, target
module brot_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // operation request
  input wire logic op_valid,
  input wire logic [`BROT_OP_W-1:0] op_code,
  input wire logic [`BROT_W-1:0] mem_rdata,
  input wire logic carry_in,
  // results
  output logic [`BROT_W-1:0] mem_wdata,
  output logic mem_we,
  output logic [`BROT_W-1:0] accumulator,
  output logic acc_we,
  output logic carry_out,
  output logic carry_we
);

  // ==========================================
  // decode
  function automatic brot_pkg::brot_ctl_t brot_decode(
    input logic [`BROT_OP_W-1:0] op);
    brot_pkg::brot_ctl_t c;
    c = '0;
    case (op)
      `BROT_OP_RL_ACC: c = 4'hd;
      `BROT_OP_RLC_MEM: c = 4'he;
      `BROT_OP_RLC_ACC: c = 4'hf;
      `BROT_OP_RR_MEM: c = 4'h8;
      default: c = '0;
    endcase
    return c;
  endfunction

  wire brot_pkg::brot_ctl_t ctl = brot_decode(op_code); // see RULE6
  wire logic take = op_valid & ctl.go;
  wire logic wrap_l = ctl.thru_c ? carry_in : mem_rdata[7]; // see RULE3
  wire logic [7:0] rot_l = {mem_rdata[6:0], wrap_l}; // see RULE1
  wire logic [7:0] rot_r = {mem_rdata[0], mem_rdata[7:1]}; // see RULE5
  wire brot_pkg::brot_res_t res_nxt = '{
    mem_we: take & ~ctl.to_acc, // see RULE2
    acc_we: take & ctl.to_acc, // see RULE4
    c_we: take & ctl.thru_c, // see RULE3
    c: ctl.thru_c ? mem_rdata[7] : carry_in,
    data: ctl.left ? rot_l : rot_r};

  // ==========================================
  // write strobes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mem_we <= 1'b0;
      acc_we <= 1'b0;
      carry_we <= 1'b0;
    end else if (clk_en) begin
      mem_we <= res_nxt.mem_we;
      acc_we <= res_nxt.acc_we;
      carry_we <= res_nxt.c_we;
    end
  end

  // result data
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mem_wdata <= `BROT_RST_BYTE;
      carry_out <= 1'b0;
    end else if (clk_en) begin
      mem_wdata <= res_nxt.data;
      carry_out <= res_nxt.c;
    end
  end

  // accumulator
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      accumulator <= `BROT_RST_BYTE;
    end else if (clk_en && res_nxt.acc_we) begin
      accumulator <= res_nxt.data; // see RULE2
    end
  end

  // ==========================================
  // checks
  property p_rl_acc;
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && op_valid && op_code == `BROT_OP_RL_ACC) |=>
      acc_we && !mem_we && !carry_we &&
      accumulator == {$past(mem_rdata[6:0]), $past(mem_rdata[7])};
  endproperty
  a_rl_acc: assert property (p_rl_acc) // see RULE1
    else $error("rl to acc wrong");

  property p_acc_no_mem;
    @(posedge clk_sys) disable iff (sys_rst)
    acc_we |-> !mem_we;
  endproperty
  a_acc_no_mem: assert property (p_acc_no_mem) // see RULE2
    else $error("acc op wrote memory");

  property p_rlc_mem;
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && op_valid && op_code == `BROT_OP_RLC_MEM) |=>
      mem_we && carry_we && carry_out == $past(mem_rdata[7]) &&
      mem_wdata == {$past(mem_rdata[6:0]), $past(carry_in)};
  endproperty
  a_rlc_mem: assert property (p_rlc_mem) // see RULE3
    else $error("rlc to memory wrong");

  property p_rlc_acc;
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && op_valid && op_code == `BROT_OP_RLC_ACC) |=>
      acc_we && !mem_we && carry_we &&
      carry_out == $past(mem_rdata[7]) &&
      accumulator == {$past(mem_rdata[6:0]), $past(carry_in)};
  endproperty
  a_rlc_acc: assert property (p_rlc_acc) // see RULE4
    else $error("rlc to acc wrong");

  property p_rr_mem;
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && op_valid && op_code == `BROT_OP_RR_MEM) |=>
      mem_we && !acc_we && !carry_we &&
      mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])};
  endproperty
  a_rr_mem: assert property (p_rr_mem) // see RULE5
    else $error("rr wrong");

  property p_idle;
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && !(op_valid && op_code inside {`BROT_OP_RL_ACC,
      `BROT_OP_RLC_MEM, `BROT_OP_RLC_ACC, `BROT_OP_RR_MEM})) |=>
      !mem_we && !acc_we && !carry_we && $stable(accumulator);
  endproperty
  a_idle: assert property (p_idle) // see RULE6
    else $error("write without valid op");

  property p_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    !clk_en |=> $stable(mem_we) && $stable(accumulator) &&
      $stable(carry_out);
  endproperty
  a_hold: assert property (p_hold) // see RULE6
    else $error("state moved while disabled");

  property p_rst_clear;
    @(posedge clk_sys)
    sys_rst |=> !mem_we && !acc_we && !carry_we && !carry_out &&
      mem_wdata == `BROT_RST_BYTE && accumulator == `BROT_RST_BYTE;
  endproperty
  a_rst_clear: assert property (p_rst_clear) // see RULE6
    else $error("outputs not cleared by reset");

  property p_carry_with_data;
    @(posedge clk_sys) disable iff (sys_rst)
    carry_we |->
      (mem_we || acc_we);
  endproperty
  a_carry_with_data: assert property (p_carry_with_data) // see RULE3
    else $error("carry written without a result");

  property p_acc_only_on_we;
    @(posedge clk_sys) disable iff (sys_rst)
    $changed(accumulator) |->
      acc_we;
  endproperty
  a_acc_only_on_we: assert property (p_acc_only_on_we) // see RULE2
    else $error("accumulator moved without a write");

  property p_rr_keeps_acc;
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && op_valid && op_code == `BROT_OP_RR_MEM) |=>
      $stable(accumulator) && !carry_we;
  endproperty
  a_rr_keeps_acc: assert property (p_rr_keeps_acc) // see RULE5
    else $error("right rotate touched acc or carry");

  property p_acc_matches_data;
    @(posedge clk_sys) disable iff (sys_rst)
    acc_we |->
      accumulator == mem_wdata;
  endproperty
  a_acc_matches_data: assert property (p_acc_matches_data) // see RULE4
    else $error("acc differs from result byte");

  property p_freeze_data;
    @(posedge clk_sys) disable iff (sys_rst)
    !clk_en |=> $stable(mem_wdata) && $stable(acc_we) &&
      $stable(carry_we);
  endproperty
  a_freeze_data: assert property (p_freeze_data) // see RULE6
    else $error("data moved while disabled");

  property p_one_target;
    @(posedge clk_sys) disable iff (sys_rst)
    mem_we |->
      !acc_we;
  endproperty
  a_one_target: assert property (p_one_target) // see RULE2
    else $error("two destinations written");

  property p_rl_acc_keeps_carry;
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && op_valid && op_code == `BROT_OP_RL_ACC) |=>
      !carry_we && !mem_we;
  endproperty
  a_rl_acc_keeps_carry: assert property (p_rl_acc_keeps_carry) // see RULE1
    else $error("rl to acc touched carry or memory");

endmodule
`default_nettype wire

// ---- sim/brot_mem_model.sv ----
// memory byte and carry flag model
`timescale 1ns/1ps
`default_nettype none
// ==========
// far-side store
module brot_mem_model (
  // clock
  input wire logic clk_sys,
  // bench preload
  input wire logic ld,
  input wire logic [7:0] ld_b,
  input wire logic ld_c,
  // unit writes
  input wire logic mwe,
  input wire logic [7:0] wd,
  input wire logic cwe,
  input wire logic co,
  // state
  output logic [7:0] mem_b,
  output logic c_f
);
  always_ff @(posedge clk_sys) begin
    mem_b <= ld ? ld_b : (mwe ? wd : mem_b);
    c_f <= ld ? ld_c : (cwe ? co : c_f);
  end
endmodule
`default_nettype wire

// ---- sim/byte_rotate_unit_tb.sv ----
// bench for the byte rotate unit
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module byte_rotate_unit_tb;
  logic clk_sys = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, ld = 1'b0;
  logic ld_c = 1'b0, mwe, awe, cwe, co, c_f;
  logic [2:0] op = 3'h0;
  logic en = 1'b1;
  logic [7:0] ld_b = 8'h00, mem_b, wd, acc;
  int bad_count = 0, check_count = 0;
  always #5 clk_sys = ~clk_sys;
  brot_unit uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(en),
    .op_valid(op_valid), .op_code(op), .mem_rdata(mem_b), .carry_in(c_f),
    .mem_wdata(wd), .mem_we(mwe), .accumulator(acc), .acc_we(awe),
    .carry_out(co), .carry_we(cwe));
  brot_mem_model mdl (.clk_sys(clk_sys), .ld(ld), .ld_b(ld_b),
    .ld_c(ld_c), .mwe(mwe), .wd(wd), .cwe(cwe), .co(co), .mem_b(mem_b),
    .c_f(c_f));
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic run(input logic [2:0] o, input logic [7:0] d, input logic c,
    input logic [7:0] e, input logic ec, input logic [2:0] w);
    @(posedge clk_sys);
    ld <= 1'b1;
    ld_b <= d;
    ld_c <= c;
    @(posedge clk_sys);
    ld <= 1'b0;
    op_valid <= 1'b1;
    op <= o;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    chk({mwe, awe, cwe} === w, "strobes");
    chk(!w[2] || wd === e, "memory result");
    chk(!w[1] || acc === e, "acc result");
    chk(!w[0] || co === ec, "carry result");
    @(posedge clk_sys);
    #1;
    chk(mem_b === (w[2] ? e : d), "memory byte");
    chk(c_f === (w[0] ? ec : c), "carry flag");
  endtask
  task automatic t_acc;
    run(3'h1, 8'h81, 1'b0, 8'h03, 1'b0, 3'h2);
    run(3'h1, 8'h4e, 1'b1, 8'h9c, 1'b0, 3'h2);
    $display("acc rotate done");
  endtask
  task automatic t_rlc;
    run(3'h2, 8'h81, 1'b0, 8'h02, 1'b1, 3'h5);
    run(3'h2, 8'h7f, 1'b1, 8'hff, 1'b0, 3'h5);
    run(3'h3, 8'h81, 1'b0, 8'h02, 1'b1, 3'h3);
    run(3'h3, 8'h40, 1'b1, 8'h81, 1'b0, 3'h3);
    $display("carry rotate done");
  endtask
  task automatic t_rr;
    run(3'h4, 8'h01, 1'b1, 8'h80, 1'b0, 3'h4);
    run(3'h4, 8'ha6, 1'b0, 8'h53, 1'b0, 3'h4);
    $display("right rotate done");
  endtask
  task automatic t_none;
    for (int i = 5; i < 9; i++) begin
      run(i[2:0], 8'h5a, 1'b1, 8'h00, 1'b0, 3'h0);
    end
    $display("ignored codes done");
  endtask
  task automatic t_freeze;
    logic [7:0] a0;
    a0 = acc;
    @(posedge clk_sys);
    ld <= 1'b1;
    ld_b <= 8'h81;
    ld_c <= 1'b0;
    @(posedge clk_sys);
    ld <= 1'b0;
    en <= 1'b0;
    op_valid <= 1'b1;
    op <= 3'h3;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    op <= 3'h0;
    @(posedge clk_sys);
    en <= 1'b1;
    #1;
    chk({mwe, awe, cwe} === 3'h0, "frozen strobes");
    chk(acc === a0 && mem_b === 8'h81, "frozen state");
    $display("clock enable done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_acc();
    t_rlc();
    t_rr();
    t_none();
    t_freeze();
    summarize();
  end
endmodule
`default_nettype wire
